/* File: rtl/key_gate.sv */
// Secure key gate: JTAG key scan-in and lock of boot, fetch and debug.
`timescale 1ns/1ps
`default_nettype none
`include "key_gate_defines.svh"

// Summary of operation
// - While secured, external boot loading stays disabled.
// - While secured, code is fetched from internal ROM only.
// - Secured and locked, debug access through the test port stays blocked.
// - A wrong key leaves the lock unchanged and grants nothing.
// - A matching, fully scanned key enables debug.
module key_gate #(
    parameter logic [`KEY_BITS-1:0] CUSTOMER_KEY = `CUSTOMER_KEY
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 secure_en,
    input  wire logic                 tck,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    input  wire logic                 trst_n,
    output logic                      tdo_r,
    output logic                      tdo_oe_n_r,
    output key_gate_pkg::grant_t      grant_r,
    output logic                      unlocked_r
);

    // Standard test-port controller states; codes are left to the tool.
    typedef enum logic [3:0] {
        TEST_RESET, IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR,
        EXIT2_DR, UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR,
        EXIT2_IR, UPD_IR
    } tap_state_t;

    // Two-stage synchronisers; only stage two is read by logic.
    key_gate_pkg::tap_pins_t meta_r;
    key_gate_pkg::tap_pins_t sync_r;
    logic                    tck_d_r;
    logic                    tck_rise;
    logic                    tck_fall;
    key_gate_pkg::tap_pins_t meta_nxt;
    key_gate_pkg::tap_pins_t sync_nxt;
    logic                    tck_d_nxt;

    // Controller state and the instruction register with its shift stage.
    tap_state_t              st_r;
    tap_state_t              st_nxt;
    logic [`IR_BITS-1:0]     ir_r;
    logic [`IR_BITS-1:0]     ir_nxt;
    logic [`IR_BITS-1:0]     irs_r;
    logic [`IR_BITS-1:0]     irs_nxt;
    logic                    unlocked_nxt;
    logic                    tdo_nxt;
    logic                    tdo_oe_n_nxt;
    key_gate_pkg::grant_t    grant_nxt;
    logic                    test_reset;
    // Key path from the shift register, and its controls.
    logic                    key_clear;
    logic                    key_shift;
    logic [`KEY_BITS-1:0]    key_val;
    logic                    key_full;

    // Next TAP state for the present state and TMS.
    function automatic tap_state_t tap_next(input tap_state_t s,
                                            input logic m);
        case (s)
            TEST_RESET: tap_next = m ? TEST_RESET : IDLE;
            IDLE:       tap_next = m ? SEL_DR : IDLE;
            SEL_DR:     tap_next = m ? SEL_IR : CAP_DR;
            CAP_DR:     tap_next = m ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:   tap_next = m ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:   tap_next = m ? UPD_DR : PAUSE_DR;
            PAUSE_DR:   tap_next = m ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:   tap_next = m ? UPD_DR : SHIFT_DR;
            UPD_DR:     tap_next = m ? SEL_DR : IDLE;
            SEL_IR:     tap_next = m ? TEST_RESET : CAP_IR;
            CAP_IR:     tap_next = m ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:   tap_next = m ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:   tap_next = m ? UPD_IR : PAUSE_IR;
            PAUSE_IR:   tap_next = m ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:   tap_next = m ? UPD_IR : SHIFT_IR;
            UPD_IR:     tap_next = m ? SEL_DR : IDLE;
            default:    tap_next = TEST_RESET;
        endcase
    endfunction

    // Test clock is sampled, so it must run well below the system clock.
    // A faster test clock would lose edges, and nothing here detects that.
    assign tck_rise   = sync_r.tck & ~tck_d_r;
    assign tck_fall   = ~sync_r.tck & tck_d_r;
    assign test_reset = ~sync_r.trst_n;

    // Key register loads only under the key-load instruction.
    // Capture clears it, so stale bits from an earlier scan never count.
    assign key_clear = test_reset | (tck_rise && st_r == CAP_DR
                                     && ir_r == `IR_KEY_LOAD);
    assign key_shift = tck_rise && st_r == SHIFT_DR
                       && ir_r == `IR_KEY_LOAD;

    key_shift_reg #(
        .KEY_W (`KEY_BITS),
        .CNT_W (`KEY_CNT_BITS)
    ) u_key (
        .clk      (clk),
        .reset    (reset),
        .clear    (key_clear),
        .shift_en (key_shift),
        .bit_in   (sync_r.tdi),
        .key_r    (key_val),
        .full_r   (key_full)
    );

    // TAP controller, instruction register and the lock itself.
    always_comb begin
        st_nxt       = st_r;
        ir_nxt       = ir_r;
        irs_nxt      = irs_r;
        unlocked_nxt = unlocked_r;
        if (test_reset) begin
            st_nxt       = TEST_RESET;
            ir_nxt       = `IR_RESET_VALUE;
            unlocked_nxt = 1'b0;
        end else if (tck_rise) begin
            st_nxt = tap_next(st_r, sync_r.tms);
            if (st_r == TEST_RESET) begin
                ir_nxt = `IR_RESET_VALUE;
            end
            // Capture loads a fixed pattern a tester uses to check the chain.
            if (st_r == CAP_IR) begin
                irs_nxt = `IR_CAPTURE;
            end
            if (st_r == SHIFT_IR) begin
                irs_nxt = {sync_r.tdi, irs_r[`IR_BITS-1:1]};
            end
            if (st_r == UPD_IR) begin
                ir_nxt = irs_r;
            end
            // Compare runs under its own instruction, so a key still being
            // shifted is never judged half way. A wrong or partial key is
            // ignored: no lock change and nothing reported.
            if (st_r == UPD_DR && ir_r == `IR_KEY_COMPARE && key_full
                && key_val == CUSTOMER_KEY) begin
                unlocked_nxt = 1'b1;
            end
        end
    end

    // Outputs: grants and TDO; TDO changes on the falling test clock.
    // Grants are plain levels that follow secure_en one clock later.
    // TDO drives only in the shift states and is released elsewhere.
    always_comb begin
        grant_nxt.boot_external_en = ~secure_en;
        grant_nxt.fetch_rom_only   = secure_en;
        grant_nxt.debug_en = ~secure_en | unlocked_r;
        tdo_nxt      = tdo_r;
        tdo_oe_n_nxt = tdo_oe_n_r;
        if (test_reset) begin
            tdo_oe_n_nxt = 1'b1;
        end else if (tck_fall) begin
            tdo_oe_n_nxt = ~(st_r == SHIFT_IR || st_r == SHIFT_DR);
            // Key data is never read back, so the key cannot leak.
            tdo_nxt = (st_r == SHIFT_IR) ? irs_r[0]
                    : (st_r == SHIFT_DR) ? unlocked_r : 1'b0;
        end
    end

    // Pin synchroniser next values. Only stage two reads stage one, so a
    // metastable first stage never reaches any logic.
    always_comb begin
        meta_nxt  = '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};
        sync_nxt  = meta_r;
        tck_d_nxt = sync_r.tck;
    end

    // Synchroniser registers. Both stages reset with trst_n low, so the
    // port sits in test-logic-reset for two more cycles after reset.
    // The test clock history resets low, its idle level, so no false
    // rising edge follows reset.
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r  <= '0;
            sync_r  <= '0;
            tck_d_r <= 1'b0;
        end else begin
            meta_r  <= meta_nxt;
            sync_r  <= sync_nxt;
            tck_d_r <= tck_d_nxt;
        end
    end

    // Port controller and lock registers. The lock has no path back to
    // zero other than the two resets.
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r       <= TEST_RESET;
            ir_r       <= `IR_RESET_VALUE;
            irs_r      <= '0;
            unlocked_r <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            ir_r       <= ir_nxt;
            irs_r      <= irs_nxt;
            unlocked_r <= unlocked_nxt;
        end
    end

    // Output registers. The gate comes out of reset secured, so grants
    // hold the locked pattern until secure_en has been sampled.
    always_ff @(posedge clk) begin
        if (reset) begin
            tdo_r      <= 1'b0;
            tdo_oe_n_r <= 1'b1;
            grant_r    <= '{boot_external_en: 1'b0, fetch_rom_only: 1'b1,
                            debug_en: 1'b0};
        end else begin
            tdo_r      <= tdo_nxt;
            tdo_oe_n_r <= tdo_oe_n_nxt;
            grant_r    <= grant_nxt;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/key_gate_defines.svh */
// Constants for the secure key gate: key width, instructions, codes.
`ifndef KEY_GATE_DEFINES_SVH
`define KEY_GATE_DEFINES_SVH

`define KEY_BITS        64
`define KEY_CNT_BITS    7
`define IR_BITS         4
`define IR_KEY_LOAD     4'h8
`define IR_KEY_COMPARE  4'h9
`define IR_RESET_VALUE  4'hf
`define IR_CAPTURE      4'h1
`define CUSTOMER_KEY    64'h0123456789abcdef

`endif

/* File: rtl/key_gate_pkg.sv */
// Types shared by the secure key gate.
package key_gate_pkg;

    // Test access port pins after synchronisation.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } tap_pins_t;

    // Access grants driven towards the core.
    typedef struct packed {
        logic boot_external_en;
        logic fetch_rom_only;
        logic debug_en;
    } grant_t;

endpackage

/* File: rtl/key_shift_reg.sv */
// Key shift register with a count, saturating at KEY_W, of bits taken since the last load start.
`timescale 1ns/1ps
`default_nettype none
`include "key_gate_defines.svh"

module key_shift_reg #(
    parameter int KEY_W = `KEY_BITS,
    parameter int CNT_W = `KEY_CNT_BITS
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clear,
    input  wire logic             shift_en,
    input  wire logic             bit_in,
    output logic [KEY_W-1:0]      key_r,
    output logic                  full_r
);

    logic [KEY_W-1:0] key_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             full_nxt;

    // Bits enter at the top, so the first bit ends at the bottom.
    always_comb begin
        key_nxt  = key_r;
        cnt_nxt  = cnt_r;
        full_nxt = full_r;
        if (clear) begin
            key_nxt  = '0;
            cnt_nxt  = '0;
            full_nxt = 1'b0;
        end else if (shift_en) begin
            key_nxt = {bit_in, key_r[KEY_W-1:1]};
            if (!full_r) begin
                cnt_nxt  = cnt_r + 1'b1;
                full_nxt = (cnt_r == CNT_W'(KEY_W - 1));
            end
        end
    end

    // Registers only.
    always_ff @(posedge clk) begin
        if (reset) begin
            key_r  <= '0;
            cnt_r  <= '0;
            full_r <= 1'b0;
        end else begin
            key_r  <= key_nxt;
            cnt_r  <= cnt_nxt;
            full_r <= full_nxt;
        end
    end

endmodule
`default_nettype wire

/* File: verification/key_gate_sva.sv */
// Checker for the key gate grants, lock hold and reset behaviour.
`timescale 1ns/1ps
`default_nettype none
module key_gate_sva (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 secure_en,
    input wire logic                 tck,
    input wire logic                 trst_n,
    input wire key_gate_pkg::grant_t grant_r,
    input wire logic                 unlocked_r
);
    // One clock domain, so clock and disable are given once.
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_rst; $fell(reset) |-> !unlocked_r && grant_r == 3'h2;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_boot; !$past(reset) |->
        grant_r.boot_external_en == !$past(secure_en); endproperty
    a_boot: assert property (p_boot) else $error("boot grant");
    property p_rom; !$past(reset) |->
        grant_r.fetch_rom_only == $past(secure_en); endproperty
    a_rom: assert property (p_rom) else $error("rom grant");
    property p_dbg; !$past(reset) |->
        grant_r.debug_en == (!$past(secure_en) || $past(unlocked_r));
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug grant");
    // Four quiet cycles of test reset cover the pin synchroniser.
    property p_hold; unlocked_r && trst_n && $past(trst_n) &&
        $past(trst_n, 2) && $past(trst_n, 3) |=> unlocked_r; endproperty
    a_hold: assert property (p_hold) else $error("unlock lost");
    property p_trst; !trst_n [*5] |-> !unlocked_r; endproperty
    a_trst: assert property (p_trst) else $error("unlock kept");
    // An unlock needs a test clock rise, seen through the synchroniser,
    // with test reset released at the same sample.
    property p_rise; $rose(unlocked_r) |-> $past(tck, 3) &&
        !$past(tck, 4) && $past(trst_n, 3); endproperty
    a_rise: assert property (p_rise) else $error("stray unlock");
endmodule
bind key_gate key_gate_sva i_key_gate_sva (.clk(clk), .reset(reset),
    .secure_en(secure_en), .tck(tck), .trst_n(trst_n),
    .grant_r(grant_r), .unlocked_r(unlocked_r));
`default_nettype wire

/* File: verification/jtag_host_model.sv */
// Behavioural test-port tester that scans keys into the gate.
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
    input  wire logic clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n
);
    // The test clock rests low between frames.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end
    // One test clock, six system clocks low and five high.
    task automatic tick(input logic m, input logic d);
        @(negedge clk);
        tms = m;
        tdi = d;
        repeat (5) @(negedge clk);
        tck = 1'b1;
        repeat (5) @(negedge clk);
        tck = 1'b0;
    endtask
    // Scan n bits of v, LSB first, from idle back to idle; idle data
    // toggles so nothing relies on a held level.
    task automatic scan(input logic ir, input logic [127:0] v,
                        input int n);
        tick(1'b1, ~tdi);
        if (ir) begin
            tick(1'b1, ~tdi);
        end
        tick(1'b0, ~tdi);
        tick(n == 0, ~tdi);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, v[i]);
        end
        tick(1'b1, ~tdi);
        tick(1'b0, ~tdi);
    endtask
    // Test reset pin held long enough for the synchroniser.
    task automatic tap_reset();
        trst_n = 1'b0;
        repeat (6) @(negedge clk);
        trst_n = 1'b1;
        repeat (4) @(negedge clk);
        tick(1'b0, ~tdi);
    endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the key gate.
`timescale 1ns/1ps
`default_nettype none
`include "key_gate_defines.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    num_errors++; $display("[ERR] %0t value mismatch", $time); end end
module testbench;
    localparam logic [63:0] TB_KEY = 64'h5a3c96e10f7b2d48;
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 secure_en = 1'b1;
    logic                 tck, tms, tdi, trst_n, tdo, tdo_oe_n, unlocked;
    key_gate_pkg::grant_t grant;
    int                   num_errors = 0;
    int                   samples_checked = 0;
    logic [63:0]          bad;
    logic                 lock_exp = 1'b0;
    // Half period of 2 ns gives 250 MHz.
    always #2 clk = ~clk;
    jtag_host_model i_jtag_host_model (.clk(clk), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_n(trst_n));
    key_gate #(.CUSTOMER_KEY(TB_KEY)) i_key_gate (.clk(clk), .reset(reset),
        .secure_en(secure_en), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo_r(tdo), .tdo_oe_n_r(tdo_oe_n),
        .grant_r(grant), .unlocked_r(unlocked));
    // Expected grants: boot, ROM only, debug.
    function automatic key_gate_pkg::grant_t exp_grant(logic s, logic u);
        return {!s, s, !s || u};
    endfunction
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Bounded wait for the lock state, then the grants two cycles later.
    task automatic check(input logic exp);
        lock_exp = exp;
        for (int i = 0; i < 20 && unlocked !== exp; i++) @(negedge clk);
        `CHK(unlocked, exp)
        if (unlocked !== exp) begin
            end_of_test();
        end
        repeat (2) @(negedge clk);
        `CHK(grant, exp_grant(secure_en, exp))
        `CHK(tdo_oe_n, 1'b1)
    endtask
    // Shift data shows the lock state, never the key being scanned in.
    task automatic watch_tdo();
        for (int i = 0; i < 200 && tdo_oe_n !== 1'b0; i++) @(negedge clk);
        `CHK(tdo_oe_n, 1'b0)
        `CHK(tdo, lock_exp)
    endtask
    // Load, scan n key bits, then compare through the update state.
    task automatic attempt(input logic [127:0] v, input int n,
                           input logic exp);
        i_jtag_host_model.scan(1'b1, `IR_KEY_LOAD, 4);
        fork
            i_jtag_host_model.scan(1'b0, v, n);
            watch_tdo();
        join
        i_jtag_host_model.scan(1'b1, `IR_KEY_COMPARE, 4);
        i_jtag_host_model.scan(1'b0, '0, 0);
        check(exp);
    endtask
    initial begin
        void'($urandom(32'h7e99415b));
        repeat (16) @(negedge clk);
        reset = 1'b0;
        i_jtag_host_model.tap_reset();
        secure_en = 1'b0;
        check(1'b0);
        secure_en = 1'b1;
        check(1'b0);
        bad = {$urandom, $urandom};
        if (bad == TB_KEY) begin
            bad[0] = ~bad[0];
        end
        attempt(bad, 64, 1'b0);
        // These 63 bits leave the register equal to the key, so only the
        // bit count can refuse them; it relies on key bit 0 being zero.
        attempt(TB_KEY >> 1, 63, 1'b0);
        attempt({TB_KEY, 32'($urandom)}, 96, 1'b1);
        attempt(bad, 64, 1'b1);
        i_jtag_host_model.tap_reset();
        check(1'b0);
        attempt(TB_KEY, 64, 1'b1);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        check(1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
